// File: rtl/i2cs_port.sv
// Purpose: two-wire bus target giving an outside controller access to registers and memory
// Assumes: pins sampled by clk_sys; open-drain outputs resolved outside
// Notes: written words leave through a FIFO; reads fetch a word per request
`timescale 1ns/100ps
module i2cs_port
  import i2cs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic low_addr_strap_pin,
  input wire logic high_addr_strap_pin,
  input wire logic pll_locked,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [SUB_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic rd_req,
  output logic [SUB_W-1:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic scl_l, sda_l, addr_bit_one, addr_bit_two;

  i2cs_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_i(scl_i),
    .level_o(scl_l)
  );
  i2cs_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_i(sda_i),
    .level_o(sda_l)
  );
  i2cs_sync #(.RST_VAL(1'b0)) u_sync_lo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_i(low_addr_strap_pin),
    .level_o(addr_bit_one)
  );
  i2cs_sync #(.RST_VAL(1'b0)) u_sync_hi (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_i(high_addr_strap_pin),
    .level_o(addr_bit_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write word FIFO
  i2cs_word_if #(.W(WORD_W)) push_if ();
  i2cs_word_if #(.W(WORD_W)) drain_if ();

  i2cs_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_if(push_if.snk),
    .out_if(drain_if.src)
  );

  assign wr_valid = drain_if.valid;
  assign drain_if.ready = wr_ready;
  assign wr_addr = drain_if.data[WORD_W-1:DATA_W];
  assign wr_data = drain_if.data[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // line events
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_l;
      sda_p_q <= sda_l;
    end
  end

  assign scl_rise = scl_l && !scl_p_q;
  assign scl_fall = !scl_l && scl_p_q;
  assign start_det = scl_l && scl_p_q && sda_p_q && !sda_l;
  assign stop_det = scl_l && scl_p_q && !sda_p_q && sda_l;

  ////////////////////////////////////////////////////////////////////////////
  // protocol state
  i2cs_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] idx_q, idx_d;
  logic rw_q, rw_d, nack_q, nack_d;
  logic [SUB_W-1:0] sub_q, sub_d;
  logic [DATA_W-1:0] word_q, word_d, load_word;
  logic [2:0] nbyte_q, nbyte_d, word_len;
  logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic [SUB_W-1:0] sub_full;
  logic sub_ok;

  assign word_len = (sub_q >= REG_BASE) ? REG_WORD_BYTES : MEM_WORD_BYTES;
  assign load_word = (sub_q >= REG_BASE) ? {rd_data[15:0], 16'h0000} : rd_data;
  assign sub_full = {sub_q[15:8], shift_q};
  assign sub_ok = pll_locked || ((sub_full >= PLL_FIRST) && (sub_full <= PLL_LAST));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    idx_d = idx_q;
    rw_d = rw_q;
    nack_d = nack_q;
    sub_d = sub_q;
    word_d = word_q;
    nbyte_d = nbyte_q;
    sda_oe_d = sda_oe_q;
    case (state_q)
      I2CS_IDLE: begin
        sda_oe_d = 1'b0;
      end
      I2CS_RX: begin
        if (scl_rise) begin
          shift_d = {shift_q[6:0], sda_l};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'h8) begin
          case (idx_q)
            2'h0: begin
              if (shift_q[7:1] == {ADDR_FIXED, addr_bit_two, addr_bit_one}) begin
                rw_d = shift_q[0];
                sda_oe_d = 1'b1;
                state_d = I2CS_ACK;
                idx_d = 2'h1;
              end else begin
                state_d = I2CS_IDLE;
              end
            end
            2'h1: begin
              sub_d = {shift_q, sub_q[7:0]};
              sda_oe_d = 1'b1;
              state_d = I2CS_ACK;
              idx_d = 2'h2;
            end
            2'h2: begin
              if (sub_ok) begin
                sub_d = sub_full;
                word_d = '0;
                nbyte_d = 3'h0;
                sda_oe_d = 1'b1;
                state_d = I2CS_ACK;
                idx_d = 2'h3;
              end else begin
                state_d = I2CS_IDLE;
              end
            end
            default: begin
              word_d = {word_q[23:0], shift_q};
              nbyte_d = nbyte_q + 3'h1;
              if (nbyte_q + 3'h1 == word_len) begin
                state_d = I2CS_PUSH;
              end else begin
                sda_oe_d = 1'b1;
                state_d = I2CS_ACK;
              end
            end
          endcase
        end
      end
      I2CS_ACK: begin
        if (scl_fall) begin
          sda_oe_d = 1'b0;
          cnt_d = 4'h0;
          shift_d = 8'h00;
          state_d = (rw_q && idx_q == 2'h1) ? I2CS_FETCH : I2CS_RX;
        end
      end
      I2CS_PUSH: begin
        if (push_if.ready) begin
          sub_d = sub_q + 16'h0001;
          word_d = '0;
          nbyte_d = 3'h0;
          sda_oe_d = 1'b1;
          state_d = I2CS_ACK;
        end
      end
      I2CS_FETCH: begin
        if (rd_valid) begin
          word_d = load_word;
          nbyte_d = 3'h0;
          cnt_d = 4'h0;
          sda_oe_d = !load_word[31];
          state_d = I2CS_TX;
        end
      end
      I2CS_TX: begin
        if (scl_fall) begin
          cnt_d = cnt_q + 4'h1;
          word_d = {word_q[30:0], 1'b0};
          if (cnt_q == 4'h7) begin
            sda_oe_d = 1'b0;
            state_d = I2CS_MACK;
          end else begin
            sda_oe_d = !word_q[30];
          end
        end
      end
      I2CS_MACK: begin
        if (scl_rise) begin
          nack_d = sda_l;
        end else if (scl_fall) begin
          if (nack_q) begin
            state_d = I2CS_IDLE;
          end else if (nbyte_q + 3'h1 == word_len) begin
            sub_d = sub_q + 16'h0001;
            state_d = I2CS_FETCH;
          end else begin
            nbyte_d = nbyte_q + 3'h1;
            cnt_d = 4'h0;
            sda_oe_d = !word_q[31];
            state_d = I2CS_TX;
          end
        end
      end
      default: begin
        state_d = I2CS_IDLE;
        sda_oe_d = 1'b0;
      end
    endcase
    if (stop_det) begin
      state_d = I2CS_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_det) begin
      state_d = I2CS_RX;
      cnt_d = 4'h0;
      shift_d = 8'h00;
      idx_d = 2'h0;
      sda_oe_d = 1'b0;
    end
    // clock only held low inside a transfer
    // one extra cycle lets the ack or first bit settle before the clock is freed
    scl_oe_d = (state_d == I2CS_PUSH) || (state_d == I2CS_FETCH) ||
      (state_q == I2CS_PUSH) || (state_q == I2CS_FETCH);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= I2CS_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sub_q <= 16'h0000;
      word_q <= '0;
      nbyte_q <= 3'h0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      sub_q <= sub_d;
      word_q <= word_d;
      nbyte_q <= nbyte_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign push_if.valid = (state_q == I2CS_PUSH);
  assign push_if.data = {sub_q, word_q};
  assign rd_req = (state_q == I2CS_FETCH);
  assign rd_addr = sub_q;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign scl_oe = scl_oe_q;
endmodule : i2cs_port

// File: rtl/i2cs_pkg.sv
// Purpose: constants and types shared by the two-wire target control port
// Assumes: clk_sys at 20 MHz, bus clock at most 400 kHz
// Notes: the operation list below is kept in step with the tags in the code
//
// Operation
// - port is target only, never starts a transfer itself.
// - address is 01110 plus high strap, low strap; 0x38 to 0x3B.
// - last bit of the first byte: one reads, zero writes.
// - while idle, watch both lines for start then own address.
// - start is data falling while clock high; opens an address byte.
// - after start, shift eight bits msb first: address then direction.
// - on match pull data low in ninth clock; else release, go idle.
// - stop is data rising while clock high; ends the transaction.
// - stop anywhere out of sequence returns to idle at once; start anywhere reopens an address byte.
// - invalid subaddress: no acknowledge, back to idle.
// - after write address, two subaddress bytes high first, then data.
// - subaddress advances by one after every acknowledged word, stops at stop.
// - registers hold two bytes per word, memory four bytes.
// - before lock only 0xF000 to 0xF004 are accepted as subaddress; advancing past them is not checked.
package i2cs_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h0E;
  localparam logic [15:0] PLL_FIRST = 16'hF000;
  localparam logic [15:0] PLL_LAST = 16'hF004;
  localparam logic [15:0] REG_BASE = 16'hF000;
  localparam logic [2:0] REG_WORD_BYTES = 3'h2;
  localparam logic [2:0] MEM_WORD_BYTES = 3'h4;
  localparam int SUB_W = 16;
  localparam int DATA_W = 32;
  localparam int WORD_W = SUB_W + DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam int SYS_PERIOD_NS = 50;
  // fastest bus clock period, used to derive SCL_MIN_CYCLES
  localparam int SCL_MIN_PERIOD_NS = 2500;
  localparam int SCL_MIN_CYCLES = SCL_MIN_PERIOD_NS / SYS_PERIOD_NS;

  typedef enum logic [3:0] {
    I2CS_IDLE = 4'h0,
    I2CS_RX = 4'h1,
    I2CS_ACK = 4'h3,
    I2CS_PUSH = 4'h2,
    I2CS_FETCH = 4'h6,
    I2CS_TX = 4'h7,
    I2CS_MACK = 4'h5
  } i2cs_state_t;
endpackage : i2cs_pkg

// File: rtl/i2cs_word_if.sv
// Purpose: valid/ready word carrier between the port and its FIFO
// Assumes: single clock domain
// Notes: src drives valid and data, snk drives ready
`timescale 1ns/100ps
interface i2cs_word_if #(parameter int W = 48);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : i2cs_word_if

// File: rtl/i2cs_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk_sys
// Notes: level changes once stages two and three agree
`timescale 1ns/100ps
module i2cs_sync #(parameter logic RST_VAL = 1'b1) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule : i2cs_sync

// File: rtl/i2cs_fifo.sv
// Purpose: synchronous word FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: in.ready low when full, out.valid low when empty
`timescale 1ns/100ps
module i2cs_fifo #(
  parameter int W = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  i2cs_word_if.snk in_if,
  i2cs_word_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic full, empty, push, pop;

  assign empty = (wptr_q == rptr_q);
  assign full = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rptr_q[AW-1:0]];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;

  always_comb begin
    wptr_d = push ? wptr_q + 1'b1 : wptr_q;
    rptr_d = pop ? rptr_q + 1'b1 : rptr_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_q[AW-1:0]] <= in_if.data;
    end
  end
endmodule : i2cs_fifo

// File: sim/i2cs_chk.sv
// Purpose: pin and handshake checks on the target port
// Assumes: bus wires pulled up, pins seen raw
// Notes: bound from the bench
`timescale 1ns/100ps
module i2cs_chk
  import i2cs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic low_addr_strap_pin,
  input wire logic high_addr_strap_pin,
  input wire logic pll_locked,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [SUB_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic [SUB_W-1:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire msb_w = (rd_addr >= 16'hF000) ? rd_data[15] : rd_data[31];
  sequence stop_s;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  sequence fetch_s;
    rd_req && rd_valid;
  endsequence
  drive_zero_a: assert property (!scl_o && !sda_o) else $error("pin value not low");
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl_i) else $error("data pulled in clock high");
  ack_fall_a: assert property ($fell(sda_oe) |-> !scl_i) else $error("data freed in clock high");
  stretch_low_a: assert property ($rose(scl_oe) |-> !scl_i) else $error("stretch began high");
  fetch_hold_a: assert property (rd_req |-> scl_oe) else $error("fetch without stretch");
  fetch_take_a: assert property (fetch_s |=> !rd_req && sda_oe == !$past(msb_w))
    else $error("first read bit wrong");
  addr_hold_a: assert property (rd_req && !rd_valid |=> $stable(rd_addr)) else $error("read address moved");
  push_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write word dropped");
  reg_word_a: assert property (wr_valid && wr_addr >= 16'hF000 |-> wr_data[31:16] == 16'h0000)
    else $error("register word too wide");
  lock_gate_a: assert property (rd_req && !pll_locked |-> rd_addr inside {[16'hF000:16'hF004]})
    else $error("fetch outside range while unlocked");
  stop_idle_a: assert property (stop_s |-> ##6 (!rd_req && !sda_oe) [*4]) else $error("busy after stop");
endmodule : i2cs_chk

// File: sim/i2cs_master_model.sv
// Purpose: behavioural bus controller driving the two wires
// Assumes: wires pulled up, outputs pull low when high
// Notes: waits on a stretched clock
`timescale 1ns/100ps
module i2cs_master_model #(parameter int Q = 625) (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic start_c;
    sda_low = 1'b0;
    #Q;
    scl_low = 1'b0;
    wait (scl_w);
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b1;
    #Q;
  endtask : start_c
  task automatic stop_c;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    wait (scl_w);
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : stop_c
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      #Q;
      scl_low = 1'b0;
      wait (scl_w);
      #Q;
      rx[i] = sda_w;
      #Q;
      scl_low = 1'b1;
      #Q;
    end
  endtask : xfer
endmodule : i2cs_master_model

// File: sim/i2cs_port_tb.sv
// Purpose: self-checking bench for the target port
// Assumes: 20 MHz system clock
// Notes: rows first, then awkward cases
`timescale 1ns/100ps
module i2cs_port_tb;
  logic clk_sys, arst_n, pll_locked, wr_ready, wr_valid, rd_req, scl_oe, sda_oe, scl_low, sda_low;
  logic rd_valid = 1'b0;
  logic [1:0] strap;
  logic [1:0] dly = 2'h0;
  logic [15:0] wr_addr, rd_addr, sub;
  logic [31:0] wr_data;
  logic [8:0] rx;
  logic [47:0] wq[$];
  int fails = 0;
  int cmp_count = 0;
  int nw;
  logic [20:0] rows [4] = '{{2'h0, 1'h0, 16'hF000, 2'h1}, {2'h1, 1'h1, 16'hF001, 2'h2},
                           {2'h2, 1'h1, 16'h0100, 2'h2}, {2'h3, 1'h0, 16'hF004, 2'h1}};
  wire scl_w = !(scl_low | scl_oe);
  wire sda_w = !(sda_low | sda_oe);
  function automatic logic [31:0] pat(input logic [15:0] a);
    pat = (a >= 16'hF000) ? {16'h0000, a ^ 16'h5A5A} : {a, ~a};
  endfunction : pat
  wire [31:0] rd_data = rd_valid ? pat(rd_addr) : ~pat(rd_addr);
  i2cs_port u_i2cs_port (.clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .low_addr_strap_pin(strap[0]), .high_addr_strap_pin(strap[1]),
    .pll_locked(pll_locked), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
  i2cs_master_model u_i2cs_master_model (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    dly <= rd_req ? dly + 2'h1 : 2'h0;
    rd_valid <= rd_req && dly == 2'h2 && !rd_valid;
  end
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready)
      wq.push_back({wr_addr, wr_data});
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic ack);
    u_i2cs_master_model.xfer({b, 1'b1}, rx);
    chk(48'(rx[0]), 48'(!ack));
  endtask : send
  task automatic hdr(input logic [7:0] adr, input logic [15:0] s, input logic ack_lo);
    u_i2cs_master_model.start_c();
    send(adr, 1'b1);
    send(s[15:8], 1'b1);
    send(s[7:0], ack_lo);
  endtask : hdr
  task automatic words(input logic [15:0] s, input int n, input logic rd);
    logic [15:0] a;
    logic [31:0] d;
    int bpw;
    for (int w = 0; w < n; w++) begin
      a = s + 16'(w);
      d = pat(a);
      bpw = (a >= 16'hF000) ? 2 : 4;
      for (int j = bpw - 1; j >= 0; j--) begin
        if (rd) begin
          u_i2cs_master_model.xfer({8'hFF, w == n - 1 && j == 0}, rx);
          chk(48'(rx[8:1]), 48'(d[8*j +: 8]));
        end else
          send(d[8*j +: 8], 1'b1);
      end
    end
  endtask : words
  task automatic expect_w(input logic [15:0] s, input int n, input string t);
    repeat (6) @(negedge clk_sys);
    chk(48'(wq.size()), 48'(n));
    for (int w = 0; w < n && w < wq.size(); w++)
      chk(wq[w], {s + 16'(w), pat(s + 16'(w))});
    wq.delete();
    $display("test %s done", t);
  endtask : expect_w
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #4ms;
    fails++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    strap = 2'h0;
    pll_locked = 1'b0;
    wr_ready = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(48'({sda_oe, scl_oe, rd_req, wr_valid}), 48'h0);
    arst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      {strap, pll_locked, sub} = rows[k][20:2];
      nw = int'(rows[k][1:0]);
      hdr({5'h0E, strap, 1'b0}, sub, 1'b1);
      words(sub, nw, 1'b0);
      u_i2cs_master_model.stop_c();
      expect_w(sub, nw, "row");
    end
    strap = 2'h0;
    pll_locked = 1'b0;
    hdr(8'h70, 16'hF002, 1'b1);
    u_i2cs_master_model.start_c();
    send(8'h71, 1'b1);
    words(16'hF002, 2, 1'b1);
    u_i2cs_master_model.stop_c();
    hdr(8'h70, 16'h0100, 1'b0);
    send(8'h55, 1'b0);
    u_i2cs_master_model.stop_c();
    u_i2cs_master_model.start_c();
    send(8'h72, 1'b0);
    u_i2cs_master_model.stop_c();
    expect_w(16'h0, 0, "refuse");
    pll_locked = 1'b1;
    hdr(8'h70, 16'h0020, 1'b1);
    send(8'hA5, 1'b1);
    u_i2cs_master_model.stop_c();
    expect_w(16'h0, 0, "partial");
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(48'({sda_oe, scl_oe, rd_req, wr_valid}), 48'h0);
    arst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    $display("test reset done");
    hdr(8'h70, 16'h0100, 1'b1);
    u_i2cs_master_model.start_c();
    send(8'h71, 1'b1);
    words(16'h0100, 2, 1'b1);
    u_i2cs_master_model.stop_c();
    $display("test memory read done");
    wr_ready = 1'b0;
    fork
      begin
        hdr(8'h70, 16'hF100, 1'b1);
        words(16'hF100, 17, 1'b0);
        u_i2cs_master_model.stop_c();
      end
      begin
        #850us;
        @(negedge clk_sys);
        chk(48'({scl_oe, wr_valid}), 48'h3);
        wr_ready = 1'b1;
      end
    join
    expect_w(16'hF100, 17, "full");
    final_report();
  end
endmodule : i2cs_port_tb
bind i2cs_port i2cs_chk u_i2cs_chk (.clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .low_addr_strap_pin(low_addr_strap_pin),
  .high_addr_strap_pin(high_addr_strap_pin), .pll_locked(pll_locked), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
